// ==== verilog/acf_defines.vh ====
// Purpose: Constants for the converter configuration and result framing block
// Assumes: APB byte addresses, 32-bit data, 50 MHz pclk
// Notes:   Definitions only
`ifndef ACF_DEFINES_VH
`define ACF_DEFINES_VH

// Register byte offsets
`define ACF_OFF_CONFIG0     8'h00
`define ACF_OFF_CONFIG1     8'h04
`define ACF_OFF_CONFIG2     8'h08
`define ACF_OFF_CONFIG3     8'h0C
`define ACF_OFF_COMMAND     8'h10
`define ACF_OFF_STATUS      8'h14
`define ACF_OFF_DATA        8'h18
`define ACF_OFF_CHECK       8'h1C

// Reset values
`define ACF_RST_CONFIG      8'h00

// Config0 fields
`define ACF_IN_SEL_HI       7
`define ACF_IN_SEL_LO       4
`define ACF_GAIN_HI         3
`define ACF_GAIN_LO         1
`define ACF_BYPASS_BIT      0
// Config1 fields
`define ACF_MODE_BIT        3
`define ACF_REF_HI          2
`define ACF_REF_LO          1
`define ACF_TEMP_BIT        0
// Config2 fields
`define ACF_CNT_EN_BIT      6
`define ACF_INTEG_HI        5
`define ACF_INTEG_LO        4
`define ACF_BURN_BIT        3
`define ACF_LEVEL_HI        2
`define ACF_LEVEL_LO        0
// Config3 fields
`define ACF_ROUTE1_HI       7
`define ACF_ROUTE1_LO       5
`define ACF_ROUTE2_HI       4
`define ACF_ROUTE2_LO       2
// Command bits
`define ACF_CMD_START_BIT   0
`define ACF_CMD_SLEEP_BIT   1
`define ACF_CMD_RESET_BIT   2

// Codes
`define ACF_MON_SUPPLY      4'hD
`define ACF_MON_REF         4'hC
`define ACF_GAIN_UNITY      3'h0
`define ACF_REF_INTERNAL    2'h0
`define ACF_LEVEL_OFF       3'h0
`define ACF_INTEG_NONE      2'h0
`define ACF_INTEG_INV       2'h1
`define ACF_INTEG_CRC       2'h2
`define ACF_CRC_POLY        16'h1021
`define ACF_CRC_INIT        16'hFFFF
`define ACF_CNT_RESET       8'h00
`define ACF_TEMP_PAD        2'h0

// Timing: single-shot conversion at the slowest rate
`define ACF_CLK_MHZ         50
`define ACF_CONV_TIME_NS    50010000
`define ACF_CLK_PERIOD_NS   20

`endif

// ==== verilog/acf_config_framing.v ====
// Purpose: Configuration control, conversion sequencing and result framing
// Assumes: APB slave on pclk, async active-low presetn, sample_data from the modulator
// Notes:   Zero-wait APB answer one cycle into the access phase
//
// What this block does
// - Both excitation sources share one level from the three-bit level field.
// - Each source has its own route field; both may share one pin.
// - Sources stay on between single shots while level nonzero; off on sleep.
// - Route 000 leaves source unconnected; nonzero level keeps bias on.
// - Burn-out enable sources into positive input, sinks from negative input.
// - Input code 1101 measures supply over four with internal reference.
// - Input code 1100 measures external reference over four, internal reference.
// - Monitor codes bypass the amplifier and force unity gain.
// - Temperature mode ignores config0 and uses internal reference.
// - Temperature result is 14-bit two's complement, left-justified, low bits zero.
// - Counter enable prefixes every result read with an 8-bit counter.
// - Counter resets to 00h, counts completed conversions, wraps FFh to 00h.
// - Clearing then setting counter enable resets it; any reset clears it.
// - Integrity 01 sends bitwise-inverted copy after the data.
// - Integrity 10 appends CCITT CRC16 preset FFFFh over output bytes.
// - Integrity covers results, the counter prefix and the low byte of register reads.
// - Any reset takes effect at once, abandoning activity.
// - Sleep lets an ongoing conversion finish before power-down.
// - Conversion mode bit selects single-shot or continuous.
// - Reset command restores defaults with no extra wait.
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`include "acf_defines.vh"

module acf_config_framing #(
    parameter CNT_W       = 22,
    parameter CONV_CYCLES = `ACF_CONV_TIME_NS / `ACF_CLK_PERIOD_NS
)(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clk_en,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [15:0] sample_data,
    output reg  [2:0]  exc_level,
    output reg         exc_enable,
    output reg  [2:0]  exc_route1,
    output reg  [2:0]  exc_route2,
    output reg         burnout_active,
    output reg  [3:0]  input_select_eff,
    output reg  [2:0]  gain_eff,
    output reg         pga_bypass_eff,
    output reg         ref_internal,
    output reg         temp_sensor_active,
    output reg         analog_power_on,
    output reg         converting,
    output reg         data_ready
);

    localparam ST_IDLE  = 3'b001;
    localparam ST_CONV  = 3'b010;
    localparam ST_SLEEP = 3'b100;

    // One CRC step over one byte, MSB first
    function [15:0] crc_byte;
        input [15:0] crc_in;
        input [7:0]  data;
        integer      i;
        reg   [15:0] c;
        begin
            c = crc_in;
            for (i = 7; i >= 0; i = i - 1)
            begin
                if (c[15] ^ data[i])
                    c = {c[14:0], 1'b0} ^ `ACF_CRC_POLY;
                else
                    c = {c[14:0], 1'b0};
            end
            crc_byte = c;
        end
    endfunction

    reg [7:0]       config0;
    reg [7:0]       config1;
    reg [7:0]       config2;
    reg [7:0]       config3;
    reg [2:0]       state;
    reg [CNT_W-1:0] conv_cnt;
    reg             sleep_pending;
    reg             run_continuous;
    reg [7:0]       result_count;
    reg [15:0]      result;
    reg [23:0]      check_word;
    reg [15:0]      samp_s1;
    reg [15:0]      samp_s2;
    reg [15:0]      samp_s3;
    reg [15:0]      samp_held;

    reg [2:0]       next_state;
    reg [31:0]      next_prdata;
    reg [23:0]      next_check;
    reg [3:0]       next_in_sel;
    reg [2:0]       next_gain;
    reg             next_bypass;
    reg             next_ref_int;
    reg [15:0]      crc_acc;

    wire acc_phase  = psel & penable & pready;
    wire wr_acc     = acc_phase & pwrite;
    wire rd_setup   = psel & ~penable & ~pwrite;
    wire cmd_wr     = wr_acc & (paddr == `ACF_OFF_COMMAND);
    wire cmd_start  = cmd_wr & pwdata[`ACF_CMD_START_BIT];
    wire cmd_sleep  = cmd_wr & pwdata[`ACF_CMD_SLEEP_BIT];
    wire cmd_reset  = cmd_wr & pwdata[`ACF_CMD_RESET_BIT];
    wire cfg_wr     = wr_acc & ((paddr == `ACF_OFF_CONFIG0) | (paddr == `ACF_OFF_CONFIG1)
                               | (paddr == `ACF_OFF_CONFIG2) | (paddr == `ACF_OFF_CONFIG3));
    wire data_rd    = acc_phase & ~pwrite & (paddr == `ACF_OFF_DATA);
    wire conv_done  = (state == ST_CONV) & (conv_cnt == CONV_CYCLES[CNT_W-1:0] - 1'b1);
    wire temp_mode  = config1[`ACF_TEMP_BIT];
    wire cnt_en     = config2[`ACF_CNT_EN_BIT];
    wire [1:0] integ = config2[`ACF_INTEG_HI:`ACF_INTEG_LO];
    wire [2:0] level = config2[`ACF_LEVEL_HI:`ACF_LEVEL_LO];
    wire [3:0] in_sel = config0[`ACF_IN_SEL_HI:`ACF_IN_SEL_LO];
    wire addr_ok    = (paddr[1:0] == 2'h0) & (paddr <= `ACF_OFF_CHECK);

    // Sample input crossing: change accepted once stages two and three agree
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            samp_s1   <= 16'h0000;
            samp_s2   <= 16'h0000;
            samp_s3   <= 16'h0000;
            samp_held <= 16'h0000;
        end
        else if (clk_en)
        begin
            samp_s1 <= sample_data;
            samp_s2 <= samp_s1;
            samp_s3 <= samp_s2;
            if (samp_s2 == samp_s3)
                samp_held <= samp_s3;
        end
    end

    // Conversion sequencing
    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (cmd_sleep)
                    next_state = ST_SLEEP;
                else if (cmd_start)
                    next_state = ST_CONV;
            end
            ST_CONV:
            begin
                if (conv_done & (sleep_pending | cmd_sleep))
                    next_state = ST_SLEEP;
                else if (conv_done & ~run_continuous)
                    next_state = ST_IDLE;
            end
            ST_SLEEP:
            begin
                if (cmd_start)
                    next_state = ST_CONV;
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state          <= ST_IDLE;
            conv_cnt       <= {CNT_W{1'b0}};
            sleep_pending  <= 1'b0;
            run_continuous <= 1'b0;
            config0        <= `ACF_RST_CONFIG;
            config1        <= `ACF_RST_CONFIG;
            config2        <= `ACF_RST_CONFIG;
            config3        <= `ACF_RST_CONFIG;
            result_count   <= `ACF_CNT_RESET;
            result         <= 16'h0000;
            data_ready     <= 1'b0;
        end
        else if (clk_en)
        begin
            if (cmd_reset)
            begin
                state          <= ST_IDLE;
                conv_cnt       <= {CNT_W{1'b0}};
                sleep_pending  <= 1'b0;
                run_continuous <= 1'b0;
                config0        <= `ACF_RST_CONFIG;
                config1        <= `ACF_RST_CONFIG;
                config2        <= `ACF_RST_CONFIG;
                config3        <= `ACF_RST_CONFIG;
                result_count   <= `ACF_CNT_RESET;
                result         <= 16'h0000;
                data_ready     <= 1'b0;
            end
            else
            begin
                state <= next_state;
                if (cmd_start)
                    run_continuous <= config1[`ACF_MODE_BIT];
                if (cmd_start | cfg_wr | conv_done)
                    conv_cnt <= {CNT_W{1'b0}};
                else if (state == ST_CONV)
                    conv_cnt <= conv_cnt + 1'b1;
                if (next_state != ST_CONV)
                    sleep_pending <= 1'b0;
                else if (cmd_sleep)
                    sleep_pending <= 1'b1;
                if (wr_acc & (paddr == `ACF_OFF_CONFIG0))
                    config0 <= pwdata[7:0];
                if (wr_acc & (paddr == `ACF_OFF_CONFIG1))
                    config1 <= pwdata[7:0];
                if (wr_acc & (paddr == `ACF_OFF_CONFIG2))
                    config2 <= pwdata[7:0];
                if (wr_acc & (paddr == `ACF_OFF_CONFIG3))
                    config3 <= pwdata[7:0];
                if (~cnt_en)
                    result_count <= `ACF_CNT_RESET;
                else if (conv_done)
                    result_count <= result_count + 8'h01;
                if (conv_done)
                begin
                    if (temp_mode)
                        result <= {samp_held[15:2], `ACF_TEMP_PAD};
                    else
                        result <= samp_held;
                end
                if (conv_done)
                    data_ready <= 1'b1;
                else if (data_rd)
                    data_ready <= 1'b0;
            end
        end
    end

    // Effective analog path selection
    always @*
    begin
        next_in_sel  = in_sel;
        next_gain    = config0[`ACF_GAIN_HI:`ACF_GAIN_LO];
        next_bypass  = config0[`ACF_BYPASS_BIT];
        next_ref_int = config1[`ACF_REF_HI:`ACF_REF_LO] == `ACF_REF_INTERNAL;
        if (temp_mode)
        begin
            next_in_sel  = 4'h0;
            next_gain    = `ACF_GAIN_UNITY;
            next_bypass  = 1'b1;
            next_ref_int = 1'b1;
        end
        else if ((in_sel == `ACF_MON_SUPPLY) | (in_sel == `ACF_MON_REF))
        begin
            next_gain    = `ACF_GAIN_UNITY;
            next_bypass  = 1'b1;
            next_ref_int = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            exc_level          <= `ACF_LEVEL_OFF;
            exc_enable         <= 1'b0;
            exc_route1         <= 3'h0;
            exc_route2         <= 3'h0;
            burnout_active     <= 1'b0;
            input_select_eff   <= 4'h0;
            gain_eff           <= `ACF_GAIN_UNITY;
            pga_bypass_eff     <= 1'b0;
            ref_internal       <= 1'b1;
            temp_sensor_active <= 1'b0;
            analog_power_on    <= 1'b0;
            converting         <= 1'b0;
        end
        else if (clk_en)
        begin
            exc_level          <= level;
            exc_enable         <= (level != `ACF_LEVEL_OFF) & (state != ST_SLEEP);
            exc_route1         <= config3[`ACF_ROUTE1_HI:`ACF_ROUTE1_LO];
            exc_route2         <= config3[`ACF_ROUTE2_HI:`ACF_ROUTE2_LO];
            burnout_active     <= config2[`ACF_BURN_BIT] & (state == ST_CONV);
            input_select_eff   <= next_in_sel;
            gain_eff           <= next_gain;
            pga_bypass_eff     <= next_bypass;
            ref_internal       <= next_ref_int;
            temp_sensor_active <= temp_mode;
            analog_power_on    <= state == ST_CONV;
            converting         <= state == ST_CONV;
        end
    end

    // Read data and integrity word for the access that follows
    always @*
    begin
        next_prdata = 32'h0000_0000;
        next_check  = 24'h00_0000;
        crc_acc     = `ACF_CRC_INIT;
        case (paddr)
            `ACF_OFF_CONFIG0: next_prdata[7:0] = config0;
            `ACF_OFF_CONFIG1: next_prdata[7:0] = config1;
            `ACF_OFF_CONFIG2: next_prdata[7:0] = config2;
            `ACF_OFF_CONFIG3: next_prdata[7:0] = config3;
            `ACF_OFF_STATUS:  next_prdata[15:0] = {result_count, data_ready,
                                                   sleep_pending, run_continuous,
                                                   2'h0, state};
            `ACF_OFF_DATA:    next_prdata[23:0] = cnt_en ? {result_count, result}
                                                         : {8'h00, result};
            `ACF_OFF_CHECK:   next_prdata[23:0] = check_word;
            default:          next_prdata = 32'h0000_0000;
        endcase
        if (paddr == `ACF_OFF_DATA)
        begin
            if (cnt_en)
                crc_acc = crc_byte(crc_acc, result_count);
            crc_acc = crc_byte(crc_acc, result[15:8]);
            crc_acc = crc_byte(crc_acc, result[7:0]);
            if (integ == `ACF_INTEG_INV)
                next_check = ~next_prdata[23:0];
        end
        else
        begin
            crc_acc = crc_byte(crc_acc, next_prdata[7:0]);
            if (integ == `ACF_INTEG_INV)
                next_check = {16'h0000, ~next_prdata[7:0]};
        end
        if (integ == `ACF_INTEG_CRC)
            next_check = {8'h00, crc_acc};
        if ((integ == `ACF_INTEG_NONE) | (paddr == `ACF_OFF_CHECK))
            next_check = check_word;
    end

    // APB slave: one access cycle, error on unmapped or misaligned address
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata     <= 32'h0000_0000;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            check_word <= 24'h00_0000;
        end
        else if (clk_en)
        begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok;
            if (rd_setup & addr_ok)
                prdata <= next_prdata;
            else if (psel & ~penable)
                prdata <= 32'h0000_0000;
            if (cmd_reset)
                check_word <= 24'h00_0000;
            else if (acc_phase & ~pwrite & addr_ok)
                check_word <= next_check;
        end
    end

endmodule

// ==== verification/acf_mod_model.sv ====
// Purpose: Modulator stand-in feeding sample_data
// Assumes: Value chosen by the bench, refreshed on pclk
// Notes:   Holds steady between bench updates
`timescale 1ns/10ps
module acf_mod_model (
    input  wire        pclk,
    input  wire [15:0] value,
    output reg  [15:0] sample_data
);
    // Sample word registered from value on each rising pclk edge
    always @(posedge pclk)
        sample_data <= value;
endmodule

// ==== verification/acf_cfg_monitor.sv ====
// Purpose: Port checker for acf_config_framing
// Assumes: One pclk domain, async active-low presetn
// Notes:   Bound into every instance of the block
`timescale 1ns/10ps
module acf_cfg_monitor (
    input wire       pclk,
    input wire       presetn,
    input wire       psel,
    input wire       penable,
    input wire       pready,
    input wire       pslverr,
    input wire [2:0] exc_level,
    input wire       exc_enable,
    input wire       burnout_active,
    input wire [3:0] input_select_eff,
    input wire [2:0] gain_eff,
    input wire       pga_bypass_eff,
    input wire       ref_internal,
    input wire       temp_sensor_active,
    input wire       converting,
    input wire       data_ready
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire mon_sel = input_select_eff[3:1] == 3'h6;
    property p_mon; mon_sel |-> gain_eff == 3'h0 && pga_bypass_eff && ref_internal; endproperty
    a_mon: assert property (p_mon) else $error("monitor code without unity gain");
    property p_temp; temp_sensor_active |-> input_select_eff == 4'h0 && ref_internal; endproperty
    a_temp: assert property (p_temp) else $error("temperature mode setup wrong");
    property p_burn; burnout_active |-> converting || $past(converting); endproperty
    a_burn: assert property (p_burn) else $error("burn-out outside conversion");
    property p_exc; exc_enable |-> exc_level != 3'h0; endproperty
    a_exc: assert property (p_exc) else $error("sources on at level zero");
    property p_exc_conv; converting && exc_level != 3'h0 |-> exc_enable; endproperty
    a_exc_conv: assert property (p_exc_conv) else $error("sources off in conversion");
    property p_done; $rose(data_ready) |-> $past(converting); endproperty
    a_done: assert property (p_done) else $error("result without conversion");
    property p_ready; pready |-> $past(psel && !penable) && psel && penable; endproperty
    a_ready: assert property (p_ready) else $error("pready without setup");
    property p_ready_one; pready |=> !pready; endproperty
    a_ready_one: assert property (p_ready_one) else $error("pready longer than one cycle");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("pslverr without pready");
    c_err: cover property (pslverr);
    c_burn: cover property (burnout_active);
    c_mon: cover property (mon_sel);
    c_done: cover property ($rose(data_ready));
endmodule

bind acf_config_framing acf_cfg_monitor u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .exc_level(exc_level), .exc_enable(exc_enable),
    .burnout_active(burnout_active), .input_select_eff(input_select_eff),
    .gain_eff(gain_eff), .pga_bypass_eff(pga_bypass_eff), .ref_internal(ref_internal),
    .temp_sensor_active(temp_sensor_active), .converting(converting),
    .data_ready(data_ready)
);

// ==== verification/acf_config_framing_tb_top.sv ====
// Purpose: Self-checking bench for acf_config_framing
// Assumes: APB master on pclk, conversion shortened to 20 cycles
// Notes:   Driver queues expected words, watcher compares them
`timescale 1ns/10ps
`include "acf_defines.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %0t: got %h exp %h", $time, g, e); end end
`define WAITC(c) begin k = 0; while (!(c) && k < 400) begin @(posedge pclk); k++; end \
    if (k == 400) begin error_cnt++; finish_test; end end
module acf_config_framing_tb_top;
    localparam CONV = 20;
    localparam [31:0] FMASK = 32'hFC7F0FFF;
    localparam [11:0] MCODES = 12'h3CD;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0, rv;
    reg [15:0] smp = 16'h0;
    reg [32:0] exp_q[$], msk_q[$];
    reg [32:0] got_w, exp_w;
    wire [15:0] sample_data;
    wire [31:0] prdata;
    wire pready, pslverr, exc_enable, burnout_active, pga_bypass_eff, ref_internal;
    wire temp_sensor_active, analog_power_on, converting, data_ready;
    wire [2:0] exc_level, exc_route1, exc_route2, gain_eff;
    wire [3:0] input_select_eff;
    integer error_cnt = 0, total_checks = 0, seed = 32'h164F3A3A, i, k;
    always #10 pclk = ~pclk;
    acf_mod_model u_mod (.pclk(pclk), .value(smp), .sample_data(sample_data));
    acf_config_framing #(.CONV_CYCLES(CONV)) DUT (
        .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_data(sample_data), .exc_level(exc_level),
        .exc_enable(exc_enable), .exc_route1(exc_route1), .exc_route2(exc_route2),
        .burnout_active(burnout_active), .input_select_eff(input_select_eff),
        .gain_eff(gain_eff), .pga_bypass_eff(pga_bypass_eff), .ref_internal(ref_internal),
        .temp_sensor_active(temp_sensor_active), .analog_power_on(analog_power_on),
        .converting(converting), .data_ready(data_ready));
    // Completed transfers against the oldest queued note
    always @(posedge pclk)
        if (psel && penable && pready)
        begin
            got_w = {pslverr, prdata} & msk_q.pop_front();
            exp_w = exp_q.pop_front();
            `CHK(got_w, exp_w)
        end
    task finish_test;
        begin
            $display("checks %0d errors %0d", total_checks, error_cnt);
            if (error_cnt == 0 && total_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge pclk);
    endtask
    task apb(input w, input [7:0] a, input [31:0] d, input [32:0] e, input [32:0] m);
        begin
            exp_q.push_back(e);
            msk_q.push_back(m);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            `WAITC(pready)
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        apb(1'b1, a, d, 33'h0, {33{1'b1}});
    endtask
    task rdx(input [7:0] a, input [31:0] e, input [31:0] m);
        apb(1'b0, a, 32'h0, {1'b0, e}, {1'b1, m});
    endtask
    task conv;
        begin
            wr(`ACF_OFF_COMMAND, 32'h1);
            `WAITC(converting)
            `WAITC(!converting)
        end
    endtask
    // Host-side check word over the low nb bytes of d, MSB first
    function [15:0] crc16(input [23:0] d, input integer nb);
        integer b;
        reg [15:0] c;
        begin
            c = 16'hFFFF;
            for (b = nb * 8 - 1; b >= 0; b = b - 1)
                c = {c[14:0], 1'b0} ^ ((c[15] ^ d[b]) ? 16'h1021 : 16'h0000);
            crc16 = c;
        end
    endfunction
    initial
    begin
        tick(4);
        presetn <= 1'b1;
        @(posedge pclk);
        for (i = 0; i <= 16; i = i + 4)
            rdx(i[7:0], 32'h0, 32'hFFFFFFFF);
        apb(1'b0, 8'h20, 32'h0, {1'b1, 32'h0}, {33{1'b1}});
        apb(1'b1, 8'h02, 32'hFF, {1'b1, 32'h0}, {33{1'b1}});
        for (i = 0; i < 4; i = i + 1)
        begin
            rv = $random(seed) & FMASK[i*8 +: 8];
            wr(i * 4, rv);
            rdx(i * 4, rv, 32'hFFFFFFFF);
        end
        $display("T: registers done");
        for (i = 1; i < 8; i = i + 1)
        begin
            wr(`ACF_OFF_CONFIG2, i);
            wr(`ACF_OFF_CONFIG3, {i[2:0], i[2:0], 2'b00});
            tick(2);
            `CHK({exc_level, exc_enable, exc_route1, exc_route2}, {i[2:0], 1'b1, i[2:0], i[2:0]})
        end
        wr(`ACF_OFF_CONFIG3, 32'h0);
        tick(2);
        `CHK({exc_enable, exc_route1, exc_route2}, 7'h40)
        wr(`ACF_OFF_CONFIG2, 32'h5);
        wr(`ACF_OFF_COMMAND, 32'h2);
        tick(2);
        `CHK({exc_level, exc_enable}, 4'hA)
        $display("T: excitation done");
        wr(`ACF_OFF_CONFIG1, 32'h4);
        for (i = 0; i < 3; i = i + 1)
        begin
            wr(`ACF_OFF_CONFIG0, {MCODES[i*4 +: 4], 4'hA});
            tick(2);
            `CHK({input_select_eff, gain_eff, pga_bypass_eff, ref_internal}, (i < 2) ? {MCODES[i*4 +: 4], 5'h03} : {MCODES[i*4 +: 4], 5'h14})
        end
        wr(`ACF_OFF_CONFIG1, 32'h5);
        tick(2);
        `CHK({input_select_eff, gain_eff, pga_bypass_eff, ref_internal, temp_sensor_active}, 10'h007)
        smp <= 16'h3CE3;
        conv;
        `CHK({exc_enable, data_ready}, 2'b11)
        rdx(`ACF_OFF_DATA, 32'h00003CE0, 32'hFFFFFFFF);
        tick(2);
        `CHK(data_ready, 1'b0)
        $display("T: monitor and temperature done");
        wr(`ACF_OFF_CONFIG1, 32'h0);
        wr(`ACF_OFF_CONFIG2, 32'h8);
        wr(`ACF_OFF_COMMAND, 32'h1);
        `WAITC(converting)
        tick(2);
        `CHK({burnout_active, analog_power_on}, 2'b11)
        `WAITC(!converting)
        wr(`ACF_OFF_CONFIG2, 32'h40);
        for (i = 1; i < 258; i = i + 1)
        begin
            smp <= $random(seed);
            conv;
            if (i == 1 || i > 254)
                rdx(`ACF_OFF_DATA, {8'h0, i[7:0], smp}, 32'hFFFFFFFF);
        end
        wr(`ACF_OFF_CONFIG2, 32'h0);
        wr(`ACF_OFF_CONFIG2, 32'h50);
        conv;
        rdx(`ACF_OFF_DATA, {8'h0, 8'h01, smp}, 32'hFFFFFFFF);
        rdx(`ACF_OFF_CHECK, {8'h0, ~{8'h01, smp}}, 32'hFFFFFFFF);
        wr(`ACF_OFF_CONFIG2, 32'h60);
        conv;
        rdx(`ACF_OFF_DATA, {8'h0, 8'h02, smp}, 32'hFFFFFFFF);
        rdx(`ACF_OFF_CHECK, {16'h0, crc16({8'h02, smp}, 3)}, 32'h0000FFFF);
        rdx(`ACF_OFF_CONFIG2, 32'h60, 32'hFFFFFFFF);
        rdx(`ACF_OFF_CHECK, {16'h0, crc16(24'h60, 1)}, 32'h0000FFFF);
        wr(`ACF_OFF_COMMAND, 32'h4);
        rdx(`ACF_OFF_CONFIG2, 32'h0, 32'hFFFFFFFF);
        wr(`ACF_OFF_CONFIG2, 32'h40);
        conv;
        rdx(`ACF_OFF_DATA, {8'h0, 8'h01, smp}, 32'hFFFFFFFF);
        $display("T: counter and integrity done");
        wr(`ACF_OFF_CONFIG2, 32'h5);
        wr(`ACF_OFF_CONFIG1, 32'h8);
        wr(`ACF_OFF_COMMAND, 32'h1);
        tick(CONV * 2 + 10);
        `CHK(converting, 1'b1)
        wr(`ACF_OFF_COMMAND, 32'h2);
        `CHK(converting, 1'b1)
        `WAITC(!converting)
        tick(CONV + 5);
        `CHK({converting, data_ready, exc_enable, analog_power_on}, 4'b0100)
        $display("T: modes and sleep done");
        wr(`ACF_OFF_COMMAND, 32'h1);
        tick(5);
        #3 presetn = 1'b0;
        #1 `CHK({converting, ref_internal, exc_level}, 5'h08)
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdx(`ACF_OFF_CONFIG1, 32'h0, 32'hFFFFFFFF);
        $display("T: reset done");
        finish_test;
    end
endmodule
